// [stdc_system_tick_timer.sv]
// system tick down counter with register port and one interrupt line
// assumes the bus master is on clk and obeys one-cycle strobes
`timescale 1ns/1ps
module stdc_system_tick_timer #(
  parameter int width = stdc_pkg::cnt_width
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire stdc_pkg::stdc_bus_type bus,
  output logic [31:0] rdata,
  // interrupt
  output logic irq
);
  // refused at elaboration: counter and reload must fit the 32-bit read word
  if (width < 2 || width > 31) begin : g_bad_width
    $error("width out of range");
  end

  logic enable;
  logic [width-1:0] reload_value_reg;
  logic [width-1:0] current_value_reg;
  logic wrap_flag;
  logic irq_status;
  logic irq_enable;
  logic hit_zero;
  logic flag_read;

  function automatic logic sel(input logic [7:0] a, input logic [3:0] page,
                               input logic [3:0] off);
    sel = (a[7:4] == page) && (a[3:0] == off);
  endfunction

  assign flag_read = bus.rd && sel(bus.addr, stdc_pkg::page_timer, stdc_pkg::addr_ctrl);
  // enabled counter at one lands on zero; this counts even when a write clears it in that cycle, a write clearing any other value does not
  assign hit_zero = enable && (current_value_reg == width'(1));

  always_ff @(posedge clk) begin
    if (rst) begin
      enable <= 1'b0;
    end else if (bus.wr && sel(bus.addr, stdc_pkg::page_timer, stdc_pkg::addr_ctrl)) begin
      enable <= bus.wdata[stdc_pkg::ctrl_enable_bit];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reload_value_reg <= '0;
    end else if (bus.wr && sel(bus.addr, stdc_pkg::page_timer, stdc_pkg::addr_reload)) begin
      reload_value_reg <= bus.wdata[width-1:0];
    end
  end

  // reset to zero here, though software must not rely on it
  always_ff @(posedge clk) begin
    if (rst) begin
      current_value_reg <= '0;
    end else if (bus.wr && sel(bus.addr, stdc_pkg::page_timer, stdc_pkg::addr_current)) begin
      current_value_reg <= '0;
    end else if (enable) begin
      if (current_value_reg == '0) begin
        current_value_reg <= reload_value_reg;
      end else begin
        current_value_reg <= current_value_reg - width'(1);
      end
    end
  end

  // set wins over the clear-on-read
  always_ff @(posedge clk) begin
    if (rst) begin
      wrap_flag <= 1'b0;
    end else if (hit_zero) begin
      wrap_flag <= 1'b1;
    end else if (flag_read) begin
      wrap_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_status <= 1'b0;
    end else if (hit_zero) begin
      irq_status <= 1'b1;
    end else if (bus.wr && sel(bus.addr, stdc_pkg::page_irq, stdc_pkg::addr_int_clear)
                 && bus.wdata[stdc_pkg::irq_wrap_bit]) begin
      irq_status <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_enable <= 1'b0;
    end else if (bus.wr && sel(bus.addr, stdc_pkg::page_irq, stdc_pkg::addr_int_enable)) begin
      irq_enable <= bus.wdata[stdc_pkg::irq_wrap_bit];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= (irq_status || hit_zero) && irq_enable;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= stdc_pkg::reset_zero;
    end else if (bus.rd) begin
      rdata <= stdc_pkg::reset_zero;
      if (sel(bus.addr, stdc_pkg::page_timer, stdc_pkg::addr_ctrl)) begin
        rdata[stdc_pkg::ctrl_enable_bit] <= enable;
        rdata[stdc_pkg::ctrl_flag_bit] <= wrap_flag;
      end else if (sel(bus.addr, stdc_pkg::page_timer, stdc_pkg::addr_reload)) begin
        rdata[width-1:0] <= reload_value_reg;
      end else if (sel(bus.addr, stdc_pkg::page_timer, stdc_pkg::addr_current)) begin
        rdata[width-1:0] <= current_value_reg;
      end else if (sel(bus.addr, stdc_pkg::page_irq, stdc_pkg::addr_int_enable)) begin
        rdata[stdc_pkg::irq_wrap_bit] <= irq_enable;
      end else if (sel(bus.addr, stdc_pkg::page_timer, stdc_pkg::addr_int_status)) begin
        rdata[stdc_pkg::irq_wrap_bit] <= irq_status;
      end
    end else begin
      rdata <= stdc_pkg::reset_zero;
    end
  end
endmodule

// [stdc_pkg.sv]
// constants and types for the system tick down counter
// assumes a single 50 MHz clock and a plain register port
package stdc_pkg;
  localparam int cnt_width = 24;
  localparam logic [3:0] addr_ctrl = 4'h0;
  localparam logic [3:0] addr_reload = 4'h4;
  localparam logic [3:0] addr_current = 4'h8;
  localparam logic [3:0] addr_int_status = 4'hc;
  localparam logic [3:0] addr_int_enable = 4'h0;
  localparam logic [3:0] addr_int_clear = 4'h4;
  localparam logic [3:0] page_timer = 4'h0;
  localparam logic [3:0] page_irq = 4'h1;
  localparam int ctrl_enable_bit = 0;
  localparam int ctrl_flag_bit = 16;
  localparam int irq_wrap_bit = 0;
  localparam logic [31:0] reset_zero = 32'h0000_0000;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } stdc_bus_type;
endpackage

// [stdc_checker.sv]
// port checker for the tick counter
// assumes a bind from the bench top, one clock domain
`timescale 1ns/1ps
module stdc_checker (
  // clock, reset and register port
  input wire logic clk,
  input wire logic rst,
  input wire stdc_pkg::stdc_bus_type bus,
  input wire logic [31:0] rdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_c; bus.rd && bus.addr == 8'h08; endsequence
  sequence s_f; bus.rd && bus.addr == 8'h00; endsequence
  sequence s_e(b); bus.wr && bus.addr == 8'h00 && bus.wdata[0] == b; endsequence
  // zero reload then clear: nothing may wrap afterwards
  sequence s_z; bus.wr && bus.addr == 8'h04 && bus.wdata == 32'h0 ##1
    bus.wr && bus.addr == 8'h08; endsequence
  property p_q; !$past(bus.rd) |-> rdata == 32'h0; endproperty
  a_q: assert property (p_q) else $error("read data not idle");
  property p_w; bus.wr && bus.addr == 8'h04 ##1 bus.rd && bus.addr == 8'h04
    |=> rdata == ($past(bus.wdata, 2) & 32'hffffff); endproperty
  a_w: assert property (p_w) else $error("reload width");
  property p_d; s_e(1) ##1 s_c ##1 s_c
    |=> $past(rdata) == 32'h0 || rdata == $past(rdata) - 32'h1; endproperty
  a_d: assert property (p_d) else $error("no decrement");
  property p_g; s_e(1) ##1 s_c ##1 bus.rd && bus.addr == 8'h00 && rdata == 32'h1
    |=> rdata[16]; endproperty
  a_g: assert property (p_g) else $error("wrap flag not set");
  property p_r; s_z ##1 s_f ##1 s_f |=> !rdata[16]; endproperty
  a_r: assert property (p_r) else $error("wrap flag not cleared");
  property p_c; bus.wr && bus.addr == 8'h08 ##1 s_c |=> rdata == 32'h0; endproperty
  a_c: assert property (p_c) else $error("write did not clear");
  property p_h; s_z ##1 s_c ##1 s_c |=> rdata == 32'h0; endproperty
  a_h: assert property (p_h) else $error("zero reload not held");
  property p_s; s_e(0) ##1 s_c ##1 s_c |=> rdata == $past(rdata); endproperty
  a_s: assert property (p_s) else $error("counter not frozen");
endmodule

// [stdc_system_tick_timer_test.sv]
// bench: fixed cases, random reloads, interrupt raise, mask and clear
// assumes the package, the timer and the checker file
`timescale 1ns/1ps
module stdc_system_tick_timer_test;
  logic clk = 0, rst = 1, irq, v1 = 0, v2 = 0;
  logic [31:0] rdata, e1, e2, n, s = 32'h67ebcd18;
  stdc_pkg::stdc_bus_type bus = '0;
  int fails = 0, n_compared = 0;
  stdc_system_tick_timer stdc_system_tick_timer_i (.clk, .rst, .bus, .rdata, .irq);
  always #10 clk = ~clk;
  function logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task chk(input logic [31:0] g, x);
    n_compared++;
    fails += 32'(g !== x);
    if (g !== x) $display("unexpected at %0t: got %h", $time, g);
  endtask
  // read data stand one edge after the strobe edge, so checks lag two steps
  task st(input logic w, r, input logic [7:0] a, input logic [31:0] d, x);
    @(posedge clk);
    if (v2) chk(rdata, e2);
    {v2, e2, v1, e1} = {v1, e1, r, x};
    bus <= '{a, d, w, r};
  endtask
  task end_sim;
    $display("%0d compared, %0d failed", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #20000;
    fails++;
    end_sim;
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 0;
    st(1, 0, 8'h04, '1, 0);
    st(0, 1, 8'h04, 0, 32'hffffff);
    st(1, 0, 8'h08, s, 0);
    st(1, 0, 8'h00, 0, 0);
    st(0, 1, 8'h08, 0, 0);
    st(0, 1, 8'h08, 0, 0);
    st(1, 0, 8'h10, 1, 0);
    st(1, 0, 8'h00, 1, 0);
    for (int i = 0; i < 9; i += 8) begin
      st(1, 0, 8'h04, 0, 0);
      st(1, 0, 8'h08, 0, 0);
      repeat (2) st(0, 1, 8'(i), 0, 32'(i == 0));
    end
    st(1, 0, 8'h04, 1, 0);
    st(1, 0, 8'h08, 0, 0);
    st(1, 0, 8'h00, 1, 0);
    st(0, 1, 8'h08, 0, 1);
    st(0, 1, 8'h00, 0, 32'h10001);
    $display("fixed cases done");
    repeat (3) begin
      s = lfsr(s);
      n = s & 32'hff | 32'h4;
      st(1, 0, 8'h00, 0, 0);
      st(1, 0, 8'h08, s, 0);
      st(1, 0, 8'h04, n, 0);
      st(1, 0, 8'h00, 1, 0);
      for (int j = 0; j < 3; j++) st(0, 1, 8'h08, 0, j == 0 ? 0 : n + 1 - j);
    end
    chk(32'(irq), 1);
    st(1, 0, 8'h00, 0, 0);
    st(1, 0, 8'h10, 0, 0);
    st(0, 1, 8'h0c, 0, 1);
    st(1, 0, 8'h14, 1, 0);
    #1 chk(32'(irq), 0);
    repeat (3) st(0, 1, 8'h0c, 0, 0);
    // unmask again: a cleared status must keep the line low
    st(1, 0, 8'h10, 1, 0);
    // flag set by the wrap before the first random run, counter now frozen
    st(0, 1, 8'h00, 0, 32'h10000);
    st(0, 1, 8'h00, 0, 0);
    // idle strobes drain the two read checks still in flight
    repeat (2) st(0, 0, 8'h00, 0, 0);
    chk(32'(irq), 0);
    $display("random and interrupt cases done");
    end_sim;
  end
endmodule
bind stdc_system_tick_timer stdc_checker stdc_checker_i (.clk, .rst, .bus, .rdata);
